/* File: logic/dmwd_top.sv */
// module: dual mode watchdog top with AXI4-Lite register slave and interrupt
`timescale 1ns/100ps
`default_nettype none
module dmwd_top
  import dmwd_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq,
  output logic             warmReset
);

  //============================================================================
  // reset synchroniser
  logic rstMeta_r;
  logic rstSync_n;

  // release through two flops; assertion stays asynchronous
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_r <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_n <= rstMeta_r;
    end
  end

  //============================================================================
  // write channel capture
  logic [7:0]  awAddr_r;
  logic        awHave_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic        wHave_r;
  logic        doWrite;

  assign s_axi_awready = !awHave_r && !s_axi_bvalid;
  assign s_axi_wready  = !wHave_r && !s_axi_bvalid;
  assign doWrite       = awHave_r && wHave_r;

  // address and data may arrive in either order; hold each until both are here
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      awAddr_r <= 8'h0;
      awHave_r <= 1'b0;
      wData_r  <= 32'h0;
      wStrb_r  <= 4'h0;
      wHave_r  <= 1'b0;
    end else if (doWrite) begin
      awHave_r <= 1'b0;
      wHave_r  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_r <= s_axi_awaddr;
        awHave_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        wHave_r <= 1'b1;
      end
    end
  end

  // decode used by both the write and read paths
  function automatic logic mapped(input logic [7:0] a);
    unique case ({a[7:2], 2'b00})
      CTRL_OFF, TIMEOUT_OFF, LOWER_OFF, KEY_OFF,
      COUNT_OFF, STATUS_OFF, MASK_OFF: mapped = 1'b1;
      default:                         mapped = 1'b0;
    endcase
  endfunction : mapped

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0]  strb);
    for (int i = 0; i < 4; i++) begin
      old[8*i +: 8] = strb[i] ? val[8*i +: 8] : old[8*i +: 8];
    end
    merge = old;
  endfunction : merge

  //============================================================================
  // configuration registers
  dmwd_cfg_s   cfg_r;
  logic [7:0]  armCode_r;
  logic [ST_W-1:0] mask_r;
  logic [ST_W-1:0] status_r;
  logic        wrCtrl;
  logic [31:0] ctrlWord;
  logic [31:0] ctrlNxt;
  logic [31:0] maskNxt;

  assign wrCtrl   = doWrite && (awAddr_r == CTRL_OFF);
  assign ctrlWord = {16'h0, armCode_r, 6'h0, cfg_r.irqMode, cfg_r.winMode};
  assign ctrlNxt  = merge(ctrlWord, wData_r, wStrb_r);
  assign maskNxt  = merge({29'h0, mask_r}, wData_r, wStrb_r);

  // reset comes up in single threshold mode with the counter already running;
  // windowed mode needs the arm code written alongside the mode bit
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cfg_r.winMode <= 1'b0;
      cfg_r.irqMode <= 1'b0;
      cfg_r.timeout <= TIMEOUT_RST;
      cfg_r.lower   <= LOWER_RST;
      armCode_r     <= 8'h0;
      mask_r        <= MASK_RST;
    end else if (doWrite) begin
      if (wrCtrl) begin
        armCode_r     <= ctrlNxt[CTRL_ARM_POS +: CTRL_ARM_W];
        cfg_r.winMode <= ctrlNxt[CTRL_WIN_BIT] &&
                         (ctrlNxt[CTRL_ARM_POS +: CTRL_ARM_W] == WIN_ARM_CODE);
        cfg_r.irqMode <= ctrlNxt[CTRL_IRQ_BIT];
      end
      if (awAddr_r == TIMEOUT_OFF) begin
        cfg_r.timeout <= merge(cfg_r.timeout, wData_r, wStrb_r);
      end
      if (awAddr_r == LOWER_OFF) begin
        cfg_r.lower <= merge(cfg_r.lower, wData_r, wStrb_r);
      end
      if (awAddr_r == MASK_OFF) begin
        mask_r <= maskNxt[ST_W-1:0];
      end
    end
  end

  //============================================================================
  // watchdog core
  logic        keyWrite;
  logic [31:0] count;
  dmwd_evt_s   evt;

  // lanes left out of a key write read as zero, so a key that leaves out lane 0 or 1 counts as wrong
  assign keyWrite = doWrite && (awAddr_r == KEY_OFF);

  dmwd_core u_core (
    .core_clk  (core_clk),
    .rstSync_n (rstSync_n),
    .cfg       (cfg_r),
    .keyWrite  (keyWrite),
    .keyData   (merge(32'h0, wData_r, wStrb_r)),
    .count     (count),
    .evt       (evt),
    .warmReset (warmReset)
  );

  //============================================================================
  // write response
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(awAddr_r) && (awAddr_r != COUNT_OFF) &&
                      (awAddr_r != STATUS_OFF) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  //============================================================================
  // read channel
  logic        statusRead;
  logic [31:0] rdMux;

  assign s_axi_arready = !s_axi_rvalid;
  assign statusRead    = s_axi_arvalid && s_axi_arready &&
                         ({s_axi_araddr[7:2], 2'b00} == STATUS_OFF);

  always_comb begin
    unique case ({s_axi_araddr[7:2], 2'b00})
      CTRL_OFF:    rdMux = ctrlWord;
      TIMEOUT_OFF: rdMux = cfg_r.timeout;
      LOWER_OFF:   rdMux = cfg_r.lower;
      COUNT_OFF:   rdMux = count;
      STATUS_OFF:  rdMux = {29'h0, status_r};
      MASK_OFF:    rdMux = {29'h0, mask_r};
      default:     rdMux = 32'h0;
    endcase
  end

  // key register reads as zero so the key cannot be learned by reading
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdMux;
      s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  //============================================================================
  // sticky status, cleared by read; a new event in the clearing cycle wins
  logic [ST_W-1:0] evtVec;
  assign evtVec = {evt.early, evt.badKey, evt.expire};

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      status_r <= '0;
    end else begin
      status_r <= (statusRead ? '0 : status_r) | evtVec;
    end
  end

  // interrupt only in interrupt response mode
  assign irq = cfg_r.irqMode && |(status_r & mask_r);

  //============================================================================
  // warm reset length monitor, feeds the pulse length check only; it wraps past
  // 255 cycles, far beyond the pulse that the core stretches
  logic [7:0] warmLen_r;

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      warmLen_r <= 8'h0;
    end else if (warmReset) begin
      warmLen_r <= warmLen_r + 8'h1;
    end else begin
      warmLen_r <= 8'h0;
    end
  end

  //============================================================================
  // checks
  a_expire_resets: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    (count >= cfg_r.timeout) && !cfg_r.irqMode |=> warmReset && count == 32'h0)
    else $error("expiry did not raise warm reset");
  a_badkey_flag: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    keyWrite && (u_core.keyData != SERVICE_KEY) |=> status_r[ST_BADKEY_BIT])
    else $error("wrong key not flagged");
  a_goodkey_restart: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    keyWrite && u_core.keyData == SERVICE_KEY && !cfg_r.winMode |=> count == 32'h0)
    else $error("good key did not restart counter");
  a_early_window: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    keyWrite && u_core.keyData == SERVICE_KEY && cfg_r.winMode && count < cfg_r.lower
    |=> status_r[ST_EARLY_BIT])
    else $error("early key in window not flagged");
  a_window_arm: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    $rose(cfg_r.winMode) |-> armCode_r == WIN_ARM_CODE)
    else $error("windowed mode active without arm code");
  a_reset_single: assert property (@(posedge core_clk)
    $rose(rstSync_n) |-> !cfg_r.winMode ##1 count == 32'h1)
    else $error("not running single threshold after reset");
  a_warm_length: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    $rose(warmReset) |-> warmReset [*8])
    else $error("warm reset pulse too short");
  a_irq_mode: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    irq |-> cfg_r.irqMode && |(status_r & mask_r))
    else $error("interrupt without masked cause");
  a_timeout_bound: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    count > cfg_r.timeout |-> ##[0:1] count == 32'h0)
    else $error("counter ran past timeout");
  a_good_window: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    keyWrite && u_core.keyData == SERVICE_KEY && cfg_r.winMode && count >= cfg_r.lower &&
    count < cfg_r.timeout |-> !evt.early ##1 count == 32'h0)
    else $error("key inside window not accepted");
  a_status_sticky: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    !statusRead |=> (status_r & $past(status_r)) == $past(status_r))
    else $error("status bit lost without a read");
  a_read_clear: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    statusRead && evtVec == '0 |=> status_r == '0)
    else $error("status not cleared by read");
  a_irq_noreset: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    cfg_r.irqMode && !warmReset |=> !warmReset)
    else $error("warm reset raised in interrupt mode");
  a_warm_count: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    $fell(warmReset) |-> warmLen_r == 8'(WARM_RST_CYC))
    else $error("warm reset pulse length wrong");
  a_single_noearly: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    !cfg_r.winMode |-> !evt.early)
    else $error("early key flagged outside windowed mode");

  c_key_ok:  cover property (@(posedge core_clk) keyWrite && count == 32'h0);
  c_early:   cover property (@(posedge core_clk) evt.early);
  c_win_on:  cover property (@(posedge core_clk) $rose(cfg_r.winMode));
  c_irq:     cover property (@(posedge core_clk) $rose(irq));
  c_warm:    cover property (@(posedge core_clk) $rose(warmReset));

endmodule : dmwd_top
`default_nettype wire

/* File: logic/dmwd_pkg.sv */
// package: register map, field layout, reset values and timing for the dual mode watchdog
//==============================================================================
// Overview of operation
// - two modes, single threshold and windowed
// - exactly one mode active at once
// - programmed timeout sets single threshold duration
// - expiry or wrong key fails single threshold
// - failure gives warm reset or interrupt
// - after reset runs single threshold mode
// - windowed key only between lower, upper bound
// - windowed failure: no key, early, wrong
// - windowed failure gives reset or interrupt
// - windowed needs extra configuration to activate
package dmwd_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFF    = 8'h00;
  localparam logic [7:0] TIMEOUT_OFF = 8'h04;
  localparam logic [7:0] LOWER_OFF   = 8'h08;
  localparam logic [7:0] KEY_OFF     = 8'h0c;
  localparam logic [7:0] COUNT_OFF   = 8'h10;
  localparam logic [7:0] STATUS_OFF  = 8'h14;
  localparam logic [7:0] MASK_OFF    = 8'h18;

  // control fields
  localparam int CTRL_WIN_BIT   = 0;
  localparam int CTRL_IRQ_BIT   = 1;
  localparam int CTRL_ARM_POS   = 8;
  localparam int CTRL_ARM_W     = 8;
  localparam logic [7:0] WIN_ARM_CODE = 8'h5a;

  // status / mask fields
  localparam int ST_EXPIRE_BIT = 0;
  localparam int ST_BADKEY_BIT = 1;
  localparam int ST_EARLY_BIT  = 2;
  localparam int ST_W          = 3;

  // key and reset values
  localparam logic [31:0] SERVICE_KEY   = 32'h0000_a5c3;
  localparam logic [31:0] TIMEOUT_RST   = 32'h000f_ffff;
  localparam logic [31:0] LOWER_RST     = 32'h0000_0000;
  localparam logic [ST_W-1:0] MASK_RST  = 3'h0;

  // warm reset pulse length
  localparam int WARM_RST_NS   = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int WARM_RST_CYC  = (WARM_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        winMode;
    logic        irqMode;
    logic [31:0] timeout;
    logic [31:0] lower;
  } dmwd_cfg_s;

  typedef struct packed {
    logic expire;
    logic badKey;
    logic early;
  } dmwd_evt_s;

endpackage : dmwd_pkg

/* File: logic/dmwd_core.sv */
// module: watchdog counter, key check and failure response
`timescale 1ns/100ps
`default_nettype none
module dmwd_core
  import dmwd_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      rstSync_n,
  input  wire dmwd_cfg_s cfg,
  input  wire logic      keyWrite,
  input  wire logic [31:0] keyData,
  output logic [31:0]    count,
  output dmwd_evt_s      evt,
  output logic           warmReset
);

  logic        keyOk;
  logic        earlyKey;
  logic        expired;
  logic        anyFail;
  logic [7:0]  warmCnt_r;

  // windowed mode refuses keys before the lower bound; single threshold never does
  assign keyOk    = keyWrite && (keyData == SERVICE_KEY);
  assign earlyKey = keyOk && cfg.winMode && (count < cfg.lower);
  assign expired  = (count >= cfg.timeout);
  assign evt.expire = expired;
  assign evt.badKey = keyWrite && (keyData != SERVICE_KEY);
  assign evt.early  = earlyKey;
  assign anyFail  = evt.expire | evt.badKey | evt.early;

  // free counter; a good key in the window restarts it, a failure also restarts it
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      count <= 32'h0;
    end else if ((keyOk && !earlyKey) || anyFail) begin
      count <= 32'h0;
    end else begin
      count <= count + 32'h1;
    end
  end

  // warm reset stretched to a fixed pulse so the system sees it
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      warmCnt_r <= 8'h0;
    end else if (anyFail && !cfg.irqMode) begin
      warmCnt_r <= 8'(WARM_RST_CYC);
    end else if (warmCnt_r != 8'h0) begin
      warmCnt_r <= warmCnt_r - 8'h1;
    end
  end

  assign warmReset = (warmCnt_r != 8'h0);

endmodule : dmwd_core
`default_nettype wire

/* File: testbench/tb_top.sv */
// testbench: register-level scenarios for the dual mode watchdog
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import dmwd_pkg::*;
  logic        core_clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq, warmReset;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          mismatches = 0;
  int          checks_done = 0;
  int          warmCnt = 0;
  dmwd_top u_dut (
    .core_clk(core_clk), .rstn(rstn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq), .warmReset(warmReset));
  //==========================================================================
  // clock and warm reset cycle counter
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // counted on the falling edge so the registered output is settled
  always @(negedge core_clk) warmCnt <= warmCnt + int'(warmReset === 1'b1);
  //==========================================================================
  // reporting
  task automatic wrap_up;
    if (mismatches == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic hang(input string what);
    check(what, 32'h0, 32'h1);
    wrap_up();
  endtask : hang
  //==========================================================================
  // bus master: handshakes judged at the falling edge, released after the rising one
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aT, wT, aD, wD;
    int   i;
    aD = 1'b0;
    wD = 1'b0;
    @(posedge core_clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 200 && !(aD && wD); i++) begin
      @(negedge core_clk);
      aT = awvalid && awready === 1'b1;
      wT = wvalid && wready === 1'b1;
      @(posedge core_clk);
      if (aT) awvalid <= 1'b0;
      if (wT) wvalid <= 1'b0;
      aD |= aT;
      wD |= wT;
    end
    if (!(aD && wD)) hang("write address or data handshake");
    for (i = 0; i < 200; i++) begin
      @(negedge core_clk);
      if (bvalid === 1'b1) break;
    end
    if (i == 200) hang("write response");
    r = bresp;
    @(posedge core_clk);
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge core_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(negedge core_clk);
      if (arready === 1'b1) break;
    end
    if (i == 200) hang("read address handshake");
    @(posedge core_clk);
    arvalid <= 1'b0;
    for (i = 0; i < 200; i++) begin
      @(negedge core_clk);
      if (rvalid === 1'b1) break;
    end
    if (i == 200) hang("read response");
    d = rdata;
    r = rresp;
    @(posedge core_clk);
    rready <= 1'b0;
  endtask : axi_rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    check("write response", r, RESP_OKAY);
  endtask : wr
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    check(n, d, exp);
  endtask : rdc
  //==========================================================================
  // scenarios
  task automatic t_reset;
    logic [31:0] c1, c2;
    logic [1:0]  r;
    check("irq after reset", irq, 1'b0);
    rdc("timeout reset", TIMEOUT_OFF, TIMEOUT_RST);
    rdc("lower reset", LOWER_OFF, LOWER_RST);
    rdc("mask reset", MASK_OFF, 32'(MASK_RST));
    axi_rd(CTRL_OFF, c1, r);
    check("window bit after reset", c1[CTRL_WIN_BIT], 1'b0);
    axi_rd(COUNT_OFF, c1, r);
    axi_rd(COUNT_OFF, c2, r);
    check("counter runs after reset", c2 > c1, 1'b1);
  endtask : t_reset
  task automatic t_bus;
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(8'h1c, d, r);
    check("unmapped read resp", r, RESP_SLVERR);
    check("unmapped read data", d, 32'h0);
    axi_wr(COUNT_OFF, 32'h0, r);
    check("count write resp", r, RESP_SLVERR);
    rdc("key reads zero", KEY_OFF, 32'h0);
  endtask : t_bus
  task automatic t_single;
    logic [31:0] d;
    logic [1:0]  r;
    wr(TIMEOUT_OFF, 32'd300);
    wr(MASK_OFF, 32'h7);
    wr(CTRL_OFF, 32'h2);
    wr(KEY_OFF, SERVICE_KEY);
    axi_rd(COUNT_OFF, d, r);
    check("count restarted by key", d < 32'd20, 1'b1);
    rdc("no event on good key", STATUS_OFF, 32'h0);
    repeat (310) @(posedge core_clk);
    @(negedge core_clk);
    check("irq on expiry", irq, 1'b1);
    rdc("expiry status", STATUS_OFF, 32'h1);
    @(negedge core_clk);
    check("irq cleared by read", irq, 1'b0);
    wr(TIMEOUT_OFF, TIMEOUT_RST);
  endtask : t_single
  task automatic t_badkey;
    wr(MASK_OFF, 32'h0);
    wr(KEY_OFF, 32'h0000_1234);
    repeat (3) @(negedge core_clk);
    check("masked irq", irq, 1'b0);
    rdc("bad key status", STATUS_OFF, 32'h2);
    wr(MASK_OFF, 32'h7);
    wr(KEY_OFF, SERVICE_KEY ^ 32'h1);
    repeat (3) @(negedge core_clk);
    check("unmasked irq", irq, 1'b1);
    rdc("bad key status", STATUS_OFF, 32'h2);
  endtask : t_badkey
  task automatic t_window;
    wr(LOWER_OFF, 32'd100);
    wr(CTRL_OFF, 32'h0000_0003);
    wr(KEY_OFF, SERVICE_KEY);
    rdc("no window without arm code", STATUS_OFF, 32'h0);
    wr(CTRL_OFF, 32'h0000_5a03);
    wr(KEY_OFF, SERVICE_KEY);
    rdc("early key status", STATUS_OFF, 32'h4);
    repeat (120) @(posedge core_clk);
    wr(KEY_OFF, SERVICE_KEY);
    rdc("key inside window", STATUS_OFF, 32'h0);
    wr(TIMEOUT_OFF, 32'd200);
    repeat (210) @(posedge core_clk);
    rdc("no key in window", STATUS_OFF, 32'h1);
    wr(TIMEOUT_OFF, TIMEOUT_RST);
  endtask : t_window
  task automatic t_warm;
    int w0;
    w0 = warmCnt;
    check("no warm reset in irq mode", w0, 32'h0);
    wr(CTRL_OFF, 32'h0);
    wr(KEY_OFF, 32'h0);
    repeat (150) @(posedge core_clk);
    check("warm reset length", warmCnt - w0, WARM_RST_CYC);
    check("no irq in reset mode", irq, 1'b0);
  endtask : t_warm
  //==========================================================================
  // main sequence
  initial begin
    rstn    = 1'b0;
    awaddr  = 8'h0;
    awvalid = 1'b0;
    wdata   = 32'h0;
    wstrb   = 4'hf;
    wvalid  = 1'b0;
    bready  = 1'b0;
    araddr  = 8'h0;
    arvalid = 1'b0;
    rready  = 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset();
    t_bus();
    t_single();
    t_badkey();
    t_window();
    t_warm();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
